// ---- common/ipc_pkg.sv ----
// Constants, register map and types of the interrupt priority block.
// Assumes a single core clock domain and an AXI4-Lite register port.
package ipc_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_PRI1     = 8'h00;
  localparam logic [7:0] OFF_PRI2     = 8'h04;
  localparam logic [7:0] OFF_PRI3     = 8'h08;
  localparam logic [7:0] OFF_RCAUSE   = 8'h0C;
  localparam logic [7:0] OFF_CTL      = 8'h10;
  localparam logic [7:0] OFF_CTL2     = 8'h14;
  localparam logic [7:0] OFF_CTL3     = 8'h18;
  localparam logic [7:0] OFF_TMR_CTL  = 8'h1C;
  localparam logic [7:0] OFF_TMR_CNT  = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] RST_PRI1     = 8'hFF;
  localparam logic [7:0] RST_PRI2     = 8'hEF;
  localparam logic [7:0] RST_PRI3     = 8'hFF;
  localparam logic [7:0] RST_RCAUSE   = 8'h3C;
  localparam logic [7:0] RST_CTL      = 8'h00;
  localparam logic [7:0] RST_CTL2     = 8'h7F;
  localparam logic [7:0] RST_CTL3     = 8'hC0;
  localparam logic [7:0] RST_TMR_CTL  = 8'h00;
  localparam logic [7:0] MASK_ALL     = 8'hFF;
  localparam logic [7:0] MASK_PRI2    = 8'hEF;
  localparam logic [7:0] MASK_RCAUSE  = 8'hB3;
  localparam logic [7:0] MASK_CTL2    = 8'h7F;
  localparam logic [7:0] MASK_TMR_CTL = 8'h03;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RC_PRIO_EN   = 7;
  localparam int RC_WDT_TO    = 3;
  localparam int RC_PWR_DOWN  = 2;
  localparam int CTL_GIE      = 7;
  localparam int CTL_PERIPHERAL_IRQ_GATE     = 6;
  localparam int CTL_TIMER_ZERO_COUNT_IE  = 5;
  localparam int CTL_EXT0_IE  = 4;
  localparam int CTL_PORT_B_PINS_IE = 3;
  localparam int CTL_TIMER_ZERO_COUNT_IF  = 2;
  localparam int CTL_EXT0_IF  = 1;
  localparam int CTL_PORT_B_PINS_IF = 0;
  localparam int CTL2_EDGE0   = 6;
  localparam int CTL2_TIMER_ZERO_COUNT_IP = 2;
  localparam int CTL2_EXT3_IP = 1;
  localparam int CTL2_PORT_B_PINS_IP = 0;
  localparam int CTL3_EXT2_IP = 7;
  localparam int CTL3_EXT1_IP = 6;
  localparam int CTL3_EXT1_IE = 3;
  localparam int CTL3_EXT1_IF = 0;
  localparam int TMR_RUN      = 0;
  localparam int TMR_WIDE     = 1;

  // ****************************************
  // Sizes, codes and types
  // ****************************************
  localparam int          PC_W        = 21;
  localparam int          STACK_DEPTH = 8;
  localparam logic [3:0]  SP_FULL     = 4'h8;
  localparam logic [7:0]  TMR_TOP8    = 8'hFF;
  localparam logic [15:0] TMR_TOP16   = 16'hFFFF;
  localparam logic [1:0]  PM_RUN      = 2'h0;
  localparam logic [1:0]  PM_DEEP     = 2'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SVC_IDLE, SVC_LOW, SVC_HIGH, SVC_BOTH} ipc_svc_t;

endpackage

// ---- hdl/ipc_top.sv ----
// Interrupt priority, external pin, timer-0 and port-B change logic.
// Assumes synchronous source inputs and a core that acknowledges requests.
`timescale 1ns/1ps
module ipc_top
  import ipc_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  // AXI4-Lite register port
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Interrupt sources
  input  wire logic [3:0]        EXT_LINES,
  input  wire logic [3:0]        PORT_B_PINS,
  input  wire logic [23:0]       PERIPH_REQ,
  // Reset-cause events
  input  wire logic              WDT_EXPIRED,
  input  wire logic              SLEEP_ENTERED,
  // Core side
  input  wire logic [1:0]        POWER_MODE,
  input  wire logic              CORE_ACK,
  input  wire logic              CORE_RETURN,
  input  wire logic [PC_W-1:0]   CORE_PC,
  input  wire logic [7:0]        CORE_WORKING_REGISTER,
  input  wire logic [7:0]        CORE_STATUS,
  input  wire logic [7:0]        CORE_BSR,
  output logic                   IRQ_HIGH,
  output logic                   IRQ_LOW,
  output logic                   WAKE,
  output logic [PC_W-1:0]        RET_PC,
  output logic [7:0]             RET_WORKING_REGISTER,
  output logic [7:0]             RET_STATUS,
  output logic [7:0]             RET_BSR
);

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask,
                                       input logic       we);
    merge = we ? ((new_v & mask) | (old_v & ~mask)) : old_v;
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0]  pri1_q, pri2_q, pri3_q, rcause_q, ctl_q, ctl2_q, ctl3_q;
  logic [7:0]  tctl_q;
  logic [15:0] tmr_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [3:0]  sp_q;
  ipc_svc_t    svc_q;

  wire wr_go   = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
  wire wr_en   = wr_go & S_AXI_WSTRB[0];
  wire [7:0] wd = S_AXI_WDATA[7:0];
  wire wr_pri1 = wr_en & (S_AXI_AWADDR == OFF_PRI1);
  wire wr_pri2 = wr_en & (S_AXI_AWADDR == OFF_PRI2);
  wire wr_pri3 = wr_en & (S_AXI_AWADDR == OFF_PRI3);
  wire wr_rc   = wr_en & (S_AXI_AWADDR == OFF_RCAUSE);
  wire wr_ctl  = wr_en & (S_AXI_AWADDR == OFF_CTL);
  wire wr_ctl2 = wr_en & (S_AXI_AWADDR == OFF_CTL2);
  wire wr_ctl3 = wr_en & (S_AXI_AWADDR == OFF_CTL3);
  wire wr_tctl = wr_en & (S_AXI_AWADDR == OFF_TMR_CTL);
  wire wr_tcnt = wr_go & (S_AXI_AWADDR == OFF_TMR_CNT);
  wire wr_hit  = (S_AXI_AWADDR == OFF_PRI1) | (S_AXI_AWADDR == OFF_PRI2)
               | (S_AXI_AWADDR == OFF_PRI3) | (S_AXI_AWADDR == OFF_RCAUSE)
               | (S_AXI_AWADDR == OFF_CTL) | (S_AXI_AWADDR == OFF_CTL2)
               | (S_AXI_AWADDR == OFF_CTL3) | (S_AXI_AWADDR == OFF_TMR_CTL)
               | (S_AXI_AWADDR == OFF_TMR_CNT)
               | (S_AXI_AWADDR == OFF_STATUS);
  wire rd_go   = S_AXI_ARVALID & ~rvalid_q;

  // Address and data taken together, so no skid storage is needed
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;

  wire in_hi = (svc_q == SVC_HIGH) | (svc_q == SVC_BOTH);
  wire in_lo = (svc_q == SVC_LOW) | (svc_q == SVC_BOTH);

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (S_AXI_ARADDR == OFF_PRI1) begin
      rd_mux[7:0] = pri1_q;
    end else if (S_AXI_ARADDR == OFF_PRI2) begin
      rd_mux[7:0] = pri2_q;
    end else if (S_AXI_ARADDR == OFF_PRI3) begin
      rd_mux[7:0] = pri3_q;
    end else if (S_AXI_ARADDR == OFF_RCAUSE) begin
      rd_mux[7:0] = rcause_q;
    end else if (S_AXI_ARADDR == OFF_CTL) begin
      rd_mux[7:0] = ctl_q;
    end else if (S_AXI_ARADDR == OFF_CTL2) begin
      rd_mux[7:0] = ctl2_q;
    end else if (S_AXI_ARADDR == OFF_CTL3) begin
      rd_mux[7:0] = ctl3_q;
    end else if (S_AXI_ARADDR == OFF_TMR_CTL) begin
      rd_mux[7:0] = tctl_q;
    end else if (S_AXI_ARADDR == OFF_TMR_CNT) begin
      rd_mux[15:0] = tmr_q;
    end else if (S_AXI_ARADDR == OFF_STATUS) begin
      rd_mux[7:0] = {sp_q, 2'h0, in_hi, in_lo};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= rd_mux;
      end else if (S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Source detection
  // ****************************************
  logic [3:0] ext_prev_q;
  logic [3:0] pb_prev_q;
  logic       primed_q;
  logic [3:0] ext_edge;

  // Edges ignored until one sample exists, avoiding a false edge at reset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      assign ext_edge[gi] = primed_q & (ctl2_q[CTL2_EDGE0 - gi]
                          ? (EXT_LINES[gi] & ~ext_prev_q[gi])
                          : (~EXT_LINES[gi] & ext_prev_q[gi]));
    end
  endgenerate

  wire pb_change = primed_q & (PORT_B_PINS != pb_prev_q);

  wire tmr_wrap = tctl_q[TMR_RUN] & (tctl_q[TMR_WIDE]
                ? (tmr_q == TMR_TOP16) : (tmr_q[7:0] == TMR_TOP8));
  wire [15:0] tmr_inc = tmr_q + 16'h0001;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ext_prev_q <= 4'h0;
      pb_prev_q  <= 4'h0;
      primed_q   <= 1'b0;
      tmr_q      <= 16'h0000;
    end else begin
      ext_prev_q <= EXT_LINES;
      pb_prev_q  <= PORT_B_PINS;
      primed_q   <= 1'b1;
      if (wr_tcnt) begin
        tmr_q <= S_AXI_WDATA[15:0];
      end else if (tctl_q[TMR_RUN]) begin
        tmr_q <= tctl_q[TMR_WIDE] ? tmr_inc : {tmr_q[15:8], tmr_inc[7:0]};
      end
    end
  end

  logic [7:0] rcause_d, ctl_d, ctl3_d;

  // Hardware set beats a software clear in the same cycle
  always_comb begin
    ctl_d = merge(ctl_q, wd, MASK_ALL, wr_ctl);
    ctl_d[CTL_TIMER_ZERO_COUNT_IF]  = ctl_d[CTL_TIMER_ZERO_COUNT_IF] | tmr_wrap;
    ctl_d[CTL_EXT0_IF]  = ctl_d[CTL_EXT0_IF] | ext_edge[0];
    ctl_d[CTL_PORT_B_PINS_IF] = ctl_d[CTL_PORT_B_PINS_IF] | pb_change;
    ctl3_d = merge(ctl3_q, wd, MASK_ALL, wr_ctl3);
    ctl3_d[CTL3_EXT1_IF +: 3] = ctl3_d[CTL3_EXT1_IF +: 3] | ext_edge[3:1];
    rcause_d = merge(rcause_q, wd, MASK_RCAUSE, wr_rc);
    if (WDT_EXPIRED) begin
      rcause_d[RC_WDT_TO] = 1'b0;
    end
    if (SLEEP_ENTERED) begin
      rcause_d[RC_PWR_DOWN] = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pri1_q   <= RST_PRI1;
      pri2_q   <= RST_PRI2;
      pri3_q   <= RST_PRI3;
      rcause_q <= RST_RCAUSE;
      ctl_q    <= RST_CTL;
      ctl2_q   <= RST_CTL2;
      ctl3_q   <= RST_CTL3;
      tctl_q   <= RST_TMR_CTL;
    end else begin
      pri1_q   <= merge(pri1_q, wd, MASK_ALL, wr_pri1);
      pri2_q   <= merge(pri2_q, wd, MASK_PRI2, wr_pri2);
      pri3_q   <= merge(pri3_q, wd, MASK_ALL, wr_pri3);
      rcause_q <= rcause_d;
      ctl_q    <= ctl_d;
      ctl2_q   <= merge(ctl2_q, wd, MASK_CTL2, wr_ctl2);
      ctl3_q   <= ctl3_d;
      tctl_q   <= merge(tctl_q, wd, MASK_TMR_CTL, wr_tctl);
    end
  end

  // ****************************************
  // Request routing
  // ****************************************
  wire        prio_en = rcause_q[RC_PRIO_EN];
  wire        global_irq_enable     = ctl_q[CTL_GIE];
  wire        peripheral_irq_gate    = ctl_q[CTL_PERIPHERAL_IRQ_GATE];
  wire [5:0]  core_flag = {ctl_q[CTL_PORT_B_PINS_IF], ctl_q[CTL_TIMER_ZERO_COUNT_IF],
                           ctl3_q[CTL3_EXT1_IF +: 3], ctl_q[CTL_EXT0_IF]};
  wire [5:0]  core_en   = {ctl_q[CTL_PORT_B_PINS_IE], ctl_q[CTL_TIMER_ZERO_COUNT_IE],
                           ctl3_q[CTL3_EXT1_IE +: 3], ctl_q[CTL_EXT0_IE]};
  wire [5:0]  core_pri  = {ctl2_q[CTL2_PORT_B_PINS_IP], ctl2_q[CTL2_TIMER_ZERO_COUNT_IP],
                           ctl2_q[CTL2_EXT3_IP], ctl3_q[CTL3_EXT2_IP],
                           ctl3_q[CTL3_EXT1_IP], 1'b1};
  wire [5:0]  core_req  = core_flag & core_en;
  wire [5:0]  core_hi   = prio_en ? core_pri : 6'h3F;
  wire [23:0] per_pri   = {pri3_q, pri2_q, pri1_q};
  wire [23:0] per_req   = PERIPH_REQ & {24{prio_en | peripheral_irq_gate}};
  wire [23:0] per_hi    = prio_en ? per_pri : 24'hFF_FFFF;
  wire        hi_req    = |(core_req & core_hi) | |(per_req & per_hi);
  wire        lo_req    = prio_en & (|(core_req & ~core_hi)
                                   | |(per_req & ~per_hi));
  wire        run       = (POWER_MODE == PM_RUN);

  assign IRQ_HIGH = run & global_irq_enable & hi_req & ~in_hi;
  assign IRQ_LOW  = run & global_irq_enable & peripheral_irq_gate & lo_req & (svc_q == SVC_IDLE);
  assign WAKE = ~run & ((POWER_MODE == PM_DEEP) ? core_req[0]
              : (|core_req | |per_req));

  // ****************************************
  // Service level and context
  // ****************************************
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [PC_W-1:0] ret_pc_q;
  logic [7:0]      sh_working_register_q, sh_status_q, sh_bsr_q;
  ipc_svc_t        svc_d;

  wire take_hi = CORE_ACK & IRQ_HIGH;
  wire take_lo = CORE_ACK & IRQ_LOW & ~IRQ_HIGH;
  wire take    = take_hi | take_lo;
  wire pop     = CORE_RETURN & ~take & (svc_q != SVC_IDLE);

  always_comb begin
    svc_d = svc_q;
    case (svc_q)
      SVC_IDLE: begin
        if (take_hi) begin
          svc_d = SVC_HIGH;
        end else if (take_lo) begin
          svc_d = SVC_LOW;
        end
      end
      SVC_LOW: begin
        if (take_hi) begin
          svc_d = SVC_BOTH;
        end else if (pop) begin
          svc_d = SVC_IDLE;
        end
      end
      SVC_HIGH: begin
        if (pop) begin
          svc_d = SVC_IDLE;
        end
      end
      default: begin
        if (pop) begin
          svc_d = SVC_LOW;
        end
      end
    endcase
  end

  // Stack overflow drops the push; the core owns overflow handling
  always_ff @(posedge CLOCK) begin
    if (take && sp_q != SP_FULL) begin
      stack_mem[sp_q[2:0]] <= CORE_PC;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      svc_q       <= SVC_IDLE;
      sp_q        <= 4'h0;
      ret_pc_q    <= '0;
      sh_working_register_q   <= 8'h00;
      sh_status_q <= 8'h00;
      sh_bsr_q    <= 8'h00;
    end else begin
      svc_q <= svc_d;
      if (take && sp_q != SP_FULL) begin
        sp_q <= sp_q + 4'h1;
      end else if (pop && sp_q != 4'h0) begin
        sp_q     <= sp_q - 4'h1;
        ret_pc_q <= stack_mem[3'(sp_q - 4'h1)];
      end
      if (take) begin
        sh_working_register_q   <= CORE_WORKING_REGISTER;
        sh_status_q <= CORE_STATUS;
        sh_bsr_q    <= CORE_BSR;
      end
    end
  end

  assign RET_PC     = ret_pc_q;
  assign RET_WORKING_REGISTER   = sh_working_register_q;
  assign RET_STATUS = sh_status_q;
  assign RET_BSR    = sh_bsr_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_take;
    take ##0 (sp_q != SP_FULL);
  endsequence
  sequence s_wrap8;
    tctl_q[TMR_RUN] && !tctl_q[TMR_WIDE] && tmr_q[7:0] == TMR_TOP8
      && !wr_ctl && !wr_tcnt;
  endsequence

  AST_PRI2_HOLE: assert property (pri2_q[4] == 1'b0)
    else $error("Unimplemented priority bit is set");
  AST_RISE_FLAG: assert property (ext_edge[0] && ctl2_q[CTL2_EDGE0]
    |=> ctl_q[CTL_EXT0_IF] && $past(EXT_LINES[0]) && !$past(ext_prev_q[0]))
    else $error("Rising edge did not set pin flag");
  AST_FLAG_STICKY: assert property (ctl3_q[CTL3_EXT1_IF] && !wr_ctl3
    |=> ctl3_q[CTL3_EXT1_IF])
    else $error("Pin flag dropped without a write");
  AST_PIN0_HIGH: assert property (core_req[0] && global_irq_enable && run && !in_hi
    |-> IRQ_HIGH)
    else $error("Pin 0 request not high priority");
  AST_LEGACY_GATE: assert property (!prio_en && !peripheral_irq_gate
    && core_req == 6'h00 |-> !IRQ_HIGH && !IRQ_LOW)
    else $error("Peripheral request passed closed gate");
  AST_NO_LOW_PREEMPT: assert property (in_hi |-> !IRQ_LOW)
    else $error("Low request during high service");
  AST_SINGLE_LEVEL: assert property (!prio_en |-> !IRQ_LOW)
    else $error("Low level used with levels disabled");
  AST_DEEP_WAKE: assert property (POWER_MODE == PM_DEEP
    && !core_req[0] |-> !WAKE)
    else $error("Deep sleep woken by other source");
  AST_TMR_WRAP: assert property (s_wrap8 |=> ctl_q[CTL_TIMER_ZERO_COUNT_IF]
    && tmr_q[7:0] == 8'h00)
    else $error("Timer wrap did not set flag");
  AST_PUSH: assert property (s_take |=> sp_q == $past(sp_q) + 4'h1)
    else $error("Return address not pushed");
  AST_SHADOW: assert property (take |=> RET_WORKING_REGISTER == $past(CORE_WORKING_REGISTER)
    && RET_BSR == $past(CORE_BSR) && RET_STATUS == $past(CORE_STATUS))
    else $error("Fast context not captured");
  AST_WDT_RO: assert property (!rcause_q[RC_WDT_TO]
    |=> !rcause_q[RC_WDT_TO])
    else $error("Watchdog flag set by software");

endmodule

// ---- verif/ipc_core_model.sv ----
// Behavioural core: acknowledges requests and offers its context.
// Assumes the interrupt block answers within a few core cycles.
`timescale 1ns/1ps
module ipc_core_model
  import ipc_pkg::*;
#(
  parameter logic [PC_W-1:0] RET_ADDR = 21'h01234,
  parameter logic [7:0]      WORK     = 8'hA5,
  parameter logic [7:0]      STAT     = 8'h5A,
  parameter logic [7:0]      BANK     = 8'h03
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Requests and acceptance
  input  wire logic            take,
  input  wire logic            irq_high,
  input  wire logic            irq_low,
  output logic                 ack,
  // Context at entry
  output logic [PC_W-1:0]      pc,
  output logic [7:0]           working_register,
  output logic [7:0]           status,
  output logic [7:0]           bank_select_register
);
  logic ack_q;
  // One-cycle pulse, never twice in a row
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else ack_q <= take & (irq_high | irq_low) & !ack_q;
  end
  assign ack = ack_q;
  assign pc     = RET_ADDR;
  assign working_register   = WORK;
  assign status = STAT;
  assign bank_select_register    = BANK;
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the interrupt priority block.
// Assumes only the AXI4-Lite handshake; every wait ends at the watchdog.
`timescale 1ns/1ps
module testbench
  import ipc_pkg::*;
;
  logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        wdt, slp, ack, ret, take, irq_h, irq_l, wake;
  logic [7:0]  awaddr, araddr, cw, cs, cb, rw, rs, rb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rr, wb, pmode;
  logic [3:0]  ext, pb;
  logic [23:0] preq;
  logic [20:0] cpc, rpc;
  int          n_errors, check_count, i;
  logic [7:0]  ra [7] = '{OFF_PRI1, OFF_PRI2, OFF_PRI3, OFF_RCAUSE,
                          OFF_CTL, OFF_CTL2, OFF_CTL3};
  logic [7:0]  re [7] = '{8'hFF, 8'hEF, 8'hFF, 8'h3C, 8'h00, 8'h7F, 8'hC0};

  ipc_top u_dut (.CLOCK(clock), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .EXT_LINES(ext), .PORT_B_PINS(pb),
    .PERIPH_REQ(preq), .WDT_EXPIRED(wdt), .SLEEP_ENTERED(slp),
    .POWER_MODE(pmode), .CORE_ACK(ack), .CORE_RETURN(ret), .CORE_PC(cpc),
    .CORE_WORKING_REGISTER(cw), .CORE_STATUS(cs), .CORE_BSR(cb), .IRQ_HIGH(irq_h),
    .IRQ_LOW(irq_l), .WAKE(wake), .RET_PC(rpc), .RET_WORKING_REGISTER(rw),
    .RET_STATUS(rs), .RET_BSR(rb));

  ipc_core_model u_core (.clk(clock), .rst_n(rst_n), .take(take),
    .irq_high(irq_h), .irq_low(irq_l), .ack(ack), .pc(cpc), .working_register(cw),
    .status(cs), .bank_select_register(cb));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clock); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clock); while (bvalid !== 1'b1);
    // Ready left high, so a next call never drops and raises it at once
    wb = bresp;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rr = rresp;
    chk(rdata, e);
  endtask

  // Requests settle one edge after the cause
  task automatic lvl(input logic [1:0] e);
    @(posedge clock);
    #1;
    chk({30'h0, irq_h, irq_l}, {30'h0, e});
    @(posedge clock);
  endtask

  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (8000) @(posedge clock);
    n_errors++;
    test_done;
  end

  initial begin
    rst_n   = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0000_0000;
    wdt     = 1'b0;
    slp     = 1'b0;
    ret     = 1'b0;
    take    = 1'b0;
    pmode   = PM_RUN;
    ext     = 4'h0;
    pb      = 4'h0;
    preq    = 24'h00_0000;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 7; i++) rd(ra[i], {24'h0, re[i]});
    wr(OFF_PRI2, 8'hFF);
    chk({30'h0, wb}, 32'h0);
    rd(OFF_PRI2, 32'hEF);
    wr(OFF_RCAUSE, 8'h00);
    rd(OFF_RCAUSE, 32'h0C);
    wr(OFF_RCAUSE, 8'hFF);
    rd(OFF_RCAUSE, 32'hBF);
    wdt <= 1'b1;
    slp <= 1'b1;
    @(posedge clock);
    wdt <= 1'b0;
    slp <= 1'b0;
    rd(OFF_RCAUSE, 32'hB3);
    rd(8'h30, 32'h0);
    chk({30'h0, rr}, 32'h2);
    wr(8'h30, 8'h00);
    chk({30'h0, wb}, 32'h2);
    // Two levels on, peripheral source 0
    wr(OFF_CTL, 8'hC0);
    wr(OFF_PRI1, 8'hFE);
    preq <= 24'h000001;
    lvl(2'b01);
    wr(OFF_PRI1, 8'hFF);
    lvl(2'b10);
    wr(OFF_PRI1, 8'hFE);
    wr(OFF_RCAUSE, 8'h33);
    lvl(2'b10);
    wr(OFF_CTL, 8'h80);
    lvl(2'b00);
    preq <= 24'h0;
    wr(OFF_RCAUSE, 8'hB3);
    // Pin 0 rising edge, entry and return
    wr(OFF_CTL, 8'h90);
    ext <= 4'h1;
    lvl(2'b10);
    take <= 1'b1;
    repeat (4) @(posedge clock);
    take <= 1'b0;
    chk({24'h0, rw}, 32'hA5);
    chk({24'h0, rs}, 32'h5A);
    chk({24'h0, rb}, 32'h03);
    rd(OFF_STATUS, 32'h12);
    ret <= 1'b1;
    @(posedge clock);
    ret <= 1'b0;
    @(posedge clock);
    #1;
    chk({11'h0, rpc}, 32'h01234);
    @(posedge clock);
    wr(OFF_CTL, 8'h10);
    // Pin 0 falling edge, wake from deepest sleep
    wr(OFF_CTL2, 8'h3F);
    ext <= 4'h0;
    // Flag lands one edge after the pin, so the read waits for it
    @(posedge clock);
    rd(OFF_CTL, 32'h12);
    pmode <= PM_DEEP;
    @(posedge clock);
    #1;
    chk({31'h0, wake}, 32'h1);
    @(posedge clock);
    wr(OFF_CTL, 8'h00);
    wr(OFF_CTL3, 8'hC8);
    ext <= 4'h2;
    @(posedge clock);
    #1;
    chk({31'h0, wake}, 32'h0);
    @(posedge clock);
    pmode <= 2'h1;
    @(posedge clock);
    #1;
    chk({31'h0, wake}, 32'h1);
    @(posedge clock);
    pmode <= PM_RUN;
    lvl(2'b00);
    // Timer wrap in narrow width, wide-mode carry and port B change
    wr(OFF_TMR_CNT, 8'hFF);
    wr(OFF_TMR_CTL, 8'h01);
    wr(OFF_TMR_CTL, 8'h00);
    rd(OFF_CTL, 32'h04);
    rd(OFF_TMR_CNT, 32'h0001);
    pb <= 4'h5;
    @(posedge clock);
    rd(OFF_CTL, 32'h05);
    wr(OFF_CTL, 8'h00);
    wr(OFF_TMR_CNT, 8'hFF);
    wr(OFF_TMR_CTL, 8'h03);
    wr(OFF_TMR_CTL, 8'h00);
    // Wide mode carries into the high byte without a flag
    rd(OFF_CTL, 32'h00);
    rd(OFF_TMR_CNT, 32'h0101);
    test_done;
  end
endmodule
